/* hw/tgdiv_top.sv */
/*
  Timing generator: prescaler, 21-stage divider, main clock enable and
  machine cycle counter, with source taps for peripherals.
  Assumes high/low basic clocks arrive as pins far slower than core_clk;
  mode and select bits come from system control logic on core_clk.
*/
// Summary of operation
// - Two-stage prescaler, 21-stage divider, main clock and cycle counters.
// - Prescaler and divider cleared on reset, stop entry and stop release.
// - Stage seven input chosen by mode, warm-up bits, stage7 select.
// - Slow and sleep modes feed stage seven from low clock unless in stop warm-up after normal mode.
// - Stop warm-up after normal mode feeds stage seven from stage six.
// - Machine cycle is four states, each one main clock period.
// - Execution lengths of one to ten machine cycles supported.
// - Execution advances only on main clock enable; divider taps for peripherals follow the basic clock ticks.
// - Divider yields pulse output, timer sources, warm-up; main clock comes from the basic clocks.
// - Independent high and low basic clock sources drive generator.
// - Single, dual and stop modes selected from system control.
// - Single clock mode machine cycle is four high clock periods.
// - Slow and sleep main clock from low clock, four periods.
// - Slow one and sleep stop first stage, freezing stages one to six.
`timescale 1ns/1ps
module tgdiv_top #(
  parameter int unsigned DIV_STAGES = 21
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                high_freq_clock,
  input  wire logic                low_freq_clock,
  input  wire tgdiv_pkg::tgdiv_ctrl_t ctrl,
  input  wire logic [3:0]          exec_len,
  input  wire logic                exec_start,
  output tgdiv_pkg::tgdiv_src_t    src,
  output logic [1:0]               mc_state,
  output logic [3:0]               mc_count,
  output logic                     exec_done,
  output logic [20:0]              div_value
);
  import tgdiv_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] hf_sync_q;
  logic [1:0] lf_sync_q;
  logic       hf_prev_q;
  logic       lf_prev_q;
  logic       hf_tick;
  logic       lf_tick;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hf_sync_q <= 2'h0;
      lf_sync_q <= 2'h0;
      hf_prev_q <= 1'b0;
      lf_prev_q <= 1'b0;
    end else begin
      hf_sync_q <= {hf_sync_q[0], high_freq_clock};
      lf_sync_q <= {lf_sync_q[0], low_freq_clock};
      hf_prev_q <= hf_sync_q[1];
      lf_prev_q <= lf_sync_q[1];
    end
  end

  assign hf_tick = hf_sync_q[1] & ~hf_prev_q;
  assign lf_tick = lf_sync_q[1] & ~lf_prev_q;

  // ----------------------------------------------------------------
  // Mode decode and clear
  // ----------------------------------------------------------------
  tgdiv_mode_t mode_q;
  logic        is_slow;
  logic        is_normal;
  logic        hi_stopped;
  logic        clr;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= TGDIV_RUN_SINGLE;
    end else begin
      mode_q <= ctrl.mode;
    end
  end

  assign is_slow = (ctrl.mode == TGDIV_SLOW_HIOFF) ||
                   (ctrl.mode == TGDIV_SLOW_HION) ||
                   (ctrl.mode == TGDIV_SLEEP_HIOFF) ||
                   (ctrl.mode == TGDIV_SLEEP_HION);
  assign is_normal = (ctrl.mode == TGDIV_RUN_SINGLE) ||
                     (ctrl.mode == TGDIV_RUN_DUAL) ||
                     (ctrl.mode == TGDIV_IDLE);
  assign hi_stopped = (ctrl.mode == TGDIV_SLOW_HIOFF) ||
                      (ctrl.mode == TGDIV_SLEEP_HIOFF) ||
                      (ctrl.mode == TGDIV_SLEEP_HION) ||
                      (ctrl.mode == TGDIV_STOP);
  // Clear on stop entry and on stop release
  assign clr = ((ctrl.mode == TGDIV_STOP) != (mode_q == TGDIV_STOP));

  // ----------------------------------------------------------------
  // Prescaler and divider chain
  // ----------------------------------------------------------------
  logic [1:0]            pre_q;
  logic                  pre_en;
  logic [DIV_STAGES:0]   carry;
  logic [DIV_STAGES-1:0] stage_q;
  logic                  stage7_en;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= PRESCALE_RESET;
    end else if (clr) begin
      pre_q <= PRESCALE_RESET;
    end else if (hf_tick && !hi_stopped) begin
      pre_q <= pre_q + 2'h1;
    end
  end

  assign pre_en = hf_tick & ~hi_stopped & (pre_q == 2'h3);

  always_comb begin
    if (ctrl.warm_from_normal && ctrl.stop_warmup) begin
      stage7_en = carry[STAGE_SIX];
    end else if (is_slow) begin
      stage7_en = lf_tick;
    end else if (ctrl.stage7_lowfreq_select &&
                 (ctrl.mode == TGDIV_RUN_DUAL)) begin
      stage7_en = lf_tick;
    end else begin
      stage7_en = carry[STAGE_SIX];
    end
  end

  assign carry[0] = pre_en;

  genvar g;
  generate
    for (g = 0; g < DIV_STAGES; g++) begin : g_div
      tgdiv_stage i_tgdiv_stage (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clr      (clr),
        .en_in    ((g == STAGE_SIX) ? stage7_en : carry[g]),
        .q        (stage_q[g]),
        .en_out   (carry[g+1])
      );
    end
  endgenerate

  assign div_value = stage_q[20:0];

  // ----------------------------------------------------------------
  // Main system clock enable
  // ----------------------------------------------------------------
  logic sys_en;

  always_comb begin
    if (ctrl.mode == TGDIV_STOP) begin
      sys_en = 1'b0;
    end else if (is_slow || (ctrl.cpu_clock_source_select && !is_normal)) begin
      sys_en = lf_tick;
    end else begin
      sys_en = hf_tick;
    end
  end

  // ----------------------------------------------------------------
  // Machine cycle counter
  // ----------------------------------------------------------------
  logic [1:0] state_q;
  logic [3:0] mc_q;
  logic [3:0] len_q;
  logic       busy_q;
  logic       done_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= STATE_RESET;
    end else if (sys_en) begin
      state_q <= state_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mc_q   <= MC_RESET;
      len_q  <= MC_LEN_MIN;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && exec_start) begin
        busy_q <= 1'b1;
        mc_q   <= MC_RESET;
        if (exec_len < MC_LEN_MIN) begin
          len_q <= MC_LEN_MIN;
        end else if (exec_len > MC_LEN_MAX) begin
          len_q <= MC_LEN_MAX;
        end else begin
          len_q <= exec_len;
        end
      end else if (busy_q && sys_en && state_q == 2'h3) begin
        if (mc_q + 4'h1 == len_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        mc_q <= mc_q + 4'h1;
      end
    end
  end

  assign mc_state  = state_q;
  assign mc_count  = mc_q;
  assign exec_done = done_q;

  // ----------------------------------------------------------------
  // Source taps
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      src <= '0;
    end else begin
      src.sys_clk_en           <= sys_en;
      src.divider_pulse_output <= stage_q[DVO_TAP];
      src.tbt_src              <= stage_q[TBT_TAP_LO +: 4];
      src.wdt_src              <= stage_q[WDT_TAP];
      src.tc_src               <= stage_q[TC_TAP_LO +: 4];
      src.warm_src             <= stage_q[WARM_TAP_LO +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clr |=> (pre_q == 2'h0))
    else $error("prescaler not cleared on stop change");

  slow_freeze_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (hi_stopped && !clr) |=> $stable(stage_q[5:0]))
    else $error("low stages moved while frozen");

  slow_stage7_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_slow && !ctrl.stop_warmup) |-> (stage7_en == lf_tick))
    else $error("stage seven not fed by low clock");

  state_wrap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (sys_en && state_q == 2'h3) |=> (state_q == 2'h0))
    else $error("state did not wrap after three");

  state_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !sys_en |=> $stable(state_q))
    else $error("state moved without main clock");

  done_len_a: assert property (@(posedge core_clk) disable iff (!resetn)
    done_q |-> (mc_q == len_q && len_q <= MC_LEN_MAX))
    else $error("cycle count mismatch at done");

  warm_stage7_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ctrl.warm_from_normal && ctrl.stop_warmup) |->
      (stage7_en == carry[STAGE_SIX]))
    else $error("warm-up stage seven not from stage six");

  fast_clock_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (ctrl.mode == TGDIV_RUN_SINGLE) |-> (sys_en == hf_tick))
    else $error("single mode main clock not high clock");

endmodule // tgdiv_top

/* shared/tgdiv_pkg.sv */
/*
  Package for the timing generator: mode codes, divider sizes, reset values
  and the carrier structs for control inputs and clock-source outputs.
  Assumes a single core_clk domain; basic clocks arrive as pins.
*/
package tgdiv_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PRESCALE_STAGES = 2;
  localparam int unsigned DIVIDER_STAGES  = 21;
  localparam int unsigned STAGE_SIX       = 6;
  localparam int unsigned STAGE_SEVEN     = 7;
  localparam int unsigned STATES_PER_MC   = 4;
  localparam int unsigned MAX_MC          = 10;
  localparam logic [1:0]  PRESCALE_RESET  = 2'h0;
  localparam logic [20:0] DIVIDER_RESET   = 21'h0;
  localparam logic [1:0]  STATE_RESET     = 2'h0;
  localparam logic [3:0]  MC_RESET        = 4'h0;
  localparam logic [3:0]  MC_LEN_MIN      = 4'h1;
  localparam logic [3:0]  MC_LEN_MAX      = 4'hA;
  localparam int unsigned DVO_TAP         = 12;
  localparam int unsigned TBT_TAP_LO      = 7;
  localparam int unsigned WDT_TAP         = 14;
  localparam int unsigned TC_TAP_LO       = 2;
  localparam int unsigned WARM_TAP_LO     = 16;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TGDIV_RUN_SINGLE   = 3'h0,
    TGDIV_RUN_DUAL     = 3'h1,
    TGDIV_SLOW_HIOFF   = 3'h3,
    TGDIV_SLOW_HION    = 3'h2,
    TGDIV_SLEEP_HIOFF  = 3'h6,
    TGDIV_SLEEP_HION   = 3'h7,
    TGDIV_STOP         = 3'h5,
    TGDIV_IDLE         = 3'h4
  } tgdiv_mode_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    tgdiv_mode_t mode;
    logic        cpu_clock_source_select;
    logic        stage7_lowfreq_select;
    logic        stop_warmup;
    logic        warm_from_normal;
  } tgdiv_ctrl_t;

  typedef struct packed {
    logic       sys_clk_en;
    logic       divider_pulse_output;
    logic [3:0] tbt_src;
    logic       wdt_src;
    logic [3:0] tc_src;
    logic [3:0] warm_src;
  } tgdiv_src_t;

endpackage

/* hw/tgdiv_stage.sv */
/*
  One binary divider stage: toggles on each input enable and passes a
  carry enable on its falling output. Assumes shared core_clk.
*/
`timescale 1ns/1ps
module tgdiv_stage (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clr,
  input  wire logic en_in,
  output logic      q,
  output logic      en_out
);
  import tgdiv_pkg::*;

  logic q_q;

  // ----------------------------------------------------------------
  // Toggle flop
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q_q <= 1'b0;
    end else if (clr) begin
      q_q <= 1'b0;
    end else if (en_in) begin
      q_q <= ~q_q;
    end
  end

  assign q      = q_q;
  assign en_out = en_in & q_q;
endmodule // tgdiv_stage

/* testbench/tgdiv_bench.sv */
/*
  Self-checking bench for the timing generator top: execution lengths per
  mode from a row table, then reset, divider and stage-seven tests.
  Assumes basic clock pins far slower than core_clk and no peripherals.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module tgdiv_bench;
  import tgdiv_pkg::*;

  typedef struct {
    tgdiv_mode_t m;
    logic        lo;
    logic [3:0]  len;
    int          ticks;
  } tgdiv_row_t;

  logic                core_clk;
  logic                resetn;
  logic                high_freq_clock;
  logic                low_freq_clock;
  tgdiv_ctrl_t         ctrl;
  logic [3:0]          exec_len;
  logic                exec_start;
  tgdiv_src_t          src;
  logic [1:0]          mc_state;
  logic [3:0]          mc_count;
  logic                exec_done;
  logic [20:0]         div_value;
  int                  fail_count;
  int                  checks_done;
  int                  sys_cnt;
  int                  done_cnt;
  logic [20:0]         slow_exp;
  tgdiv_mode_t         slow_modes [4];
  tgdiv_row_t          rows [7];

  tgdiv_top i_tgdiv_top (
    .core_clk        (core_clk),
    .resetn          (resetn),
    .high_freq_clock (high_freq_clock),
    .low_freq_clock  (low_freq_clock),
    .ctrl            (ctrl),
    .exec_len        (exec_len),
    .exec_start      (exec_start),
    .src             (src),
    .mc_state        (mc_state),
    .mc_count        (mc_count),
    .exec_done       (exec_done),
    .div_value       (div_value)
  );

  // --------------------------------------------------------------
  // Clock, monitors and watchdog
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (src.sys_clk_en === 1'b1) sys_cnt++;
    if (exec_done === 1'b1) done_cnt++;
  end

  initial begin
    #600000;
    fail_count++;
    stop_test();
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick(input logic lo, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      if (lo) low_freq_clock = 1'b1;
      else high_freq_clock = 1'b1;
      repeat (3) @(negedge core_clk);
      low_freq_clock  = 1'b0;
      high_freq_clock = 1'b0;
      repeat (3) @(negedge core_clk);
    end
  endtask

  task automatic set_ctrl(input tgdiv_mode_t m, input logic cpu,
                          input logic sel, input logic warm);
    @(negedge core_clk);
    ctrl.mode                    = m;
    ctrl.cpu_clock_source_select = cpu;
    ctrl.stage7_lowfreq_select   = sel;
    ctrl.stop_warmup             = warm;
    ctrl.warm_from_normal        = warm;
    repeat (4) @(negedge core_clk);
  endtask

  // Pass through stop so the prescaler and divider restart from zero
  task automatic clr_to(input tgdiv_mode_t m, input logic cpu,
                        input logic sel, input logic warm);
    set_ctrl(TGDIV_STOP, 1'b0, 1'b0, 1'b0);
    `CHK("div_stop_entry", 21'h0, div_value)
    set_ctrl(m, cpu, sel, warm);
    `CHK("div_stop_exit", 21'h0, div_value)
  endtask

  task automatic run_exec(input tgdiv_row_t r);
    int n;
    int d0;
    int s0;
    set_ctrl(r.m, r.lo, 1'b0, 1'b0);
    s0 = sys_cnt;
    d0 = done_cnt;
    exec_len   = r.len;
    exec_start = 1'b1;
    @(negedge core_clk);
    exec_start = 1'b0;
    n = 0;
    while (done_cnt == d0 && n < 60) begin
      tick(r.lo, 1);
      n++;
    end
    `CHK("exec_ticks", r.ticks, n)
    `CHK("sys_pulses", n, sys_cnt - s0)
    `CHK("state_end", 2'h0, mc_state)
    `CHK("mc_count", r.ticks / 4, mc_count)
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rows[0] = '{TGDIV_RUN_SINGLE, 1'b0, 4'h1, 4};
    rows[1] = '{TGDIV_RUN_SINGLE, 1'b0, 4'hA, 40};
    rows[2] = '{TGDIV_RUN_SINGLE, 1'b0, 4'h0, 4};
    rows[3] = '{TGDIV_RUN_DUAL, 1'b0, 4'hF, 40};
    rows[4] = '{TGDIV_RUN_DUAL, 1'b0, 4'h3, 12};
    rows[5] = '{TGDIV_SLOW_HION, 1'b1, 4'h2, 8};
    rows[6] = '{TGDIV_SLOW_HIOFF, 1'b1, 4'h1, 4};
    slow_modes = '{TGDIV_SLOW_HIOFF, TGDIV_SLOW_HION,
                   TGDIV_SLEEP_HIOFF, TGDIV_SLEEP_HION};
    fail_count      = 0;
    checks_done     = 0;
    sys_cnt         = 0;
    done_cnt        = 0;
    resetn          = 1'b0;
    high_freq_clock = 1'b0;
    low_freq_clock  = 1'b0;
    ctrl            = '0;
    exec_len        = 4'h1;
    exec_start      = 1'b0;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("div_reset", 21'h0, div_value)
    `CHK("src_reset", '0, src)
    `CHK("state_reset", 2'h0, mc_state)
    `CHK("count_reset", 4'h0, mc_count)
    `CHK("done_reset", 1'b0, exec_done)

    foreach (rows[i]) run_exec(rows[i]);

    // Prescaler of two stages ahead of the binary divider
    clr_to(TGDIV_RUN_SINGLE, 1'b0, 1'b0, 1'b0);
    tick(1'b0, 32);
    `CHK("div_count", 21'h8, div_value)
    `CHK("tc_tap", 4'h2, src.tc_src)
    tick(1'b0, 1);
    `CHK("state_step", 2'h1, mc_state)

    // Stage seven from low clock when selected in dual mode
    clr_to(TGDIV_RUN_DUAL, 1'b0, 1'b1, 1'b0);
    tick(1'b0, 256);
    `CHK("s7_low_sel", 21'h0, div_value)
    tick(1'b1, 1);
    `CHK("s7_low_tick", 21'h40, div_value)
    clr_to(TGDIV_RUN_DUAL, 1'b0, 1'b0, 1'b0);
    tick(1'b0, 256);
    `CHK("s7_from_s6", 21'h40, div_value)

    // Warm-up after normal mode ignores the select bit
    clr_to(TGDIV_RUN_DUAL, 1'b0, 1'b1, 1'b1);
    tick(1'b0, 256);
    `CHK("s7_warmup", 21'h40, div_value)
    // Warm-up after a slow entry keeps honouring the select bit
    clr_to(TGDIV_RUN_DUAL, 1'b0, 1'b1, 1'b1);
    ctrl.warm_from_normal = 1'b0;
    tick(1'b0, 256);
    `CHK("s7_warm_slow", 21'h0, div_value)

    // Slow and sleep: low clock into stage seven, first stages frozen except in TGDIV_SLOW_HION
    foreach (slow_modes[i]) begin
      clr_to(slow_modes[i], 1'b1, 1'b1, 1'b0);
      sys_cnt = 0;
      tick(1'b0, 4);
      `CHK("slow_hi_sys", 0, sys_cnt)
      tick(1'b1, 1);
      if (slow_modes[i] == TGDIV_SLOW_HION) slow_exp = 21'h41;
      else slow_exp = 21'h40;
      `CHK("slow_s7", slow_exp, div_value)
    end

    // Upper stages and source taps from low clock ticks
    tick(1'b1, 1373);
    `CHK("div_upper", 21'h15780, div_value)
    `CHK("dvo_tap", 1'b1, src.divider_pulse_output)
    `CHK("tbt_tap", 4'hF, src.tbt_src)
    `CHK("wdt_tap", 1'b1, src.wdt_src)
    `CHK("tc_tap_frozen", 4'h0, src.tc_src)
    `CHK("warm_tap", 4'h1, src.warm_src)

    // Reset in mid-run clears every stage and counter
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("div_rst_mid", 21'h0, div_value)
    `CHK("src_rst_mid", '0, src)
    `CHK("state_rst_mid", 2'h0, mc_state)
    `CHK("count_rst_mid", 4'h0, mc_count)
    stop_test();
  end

endmodule // tgdiv_bench
